// file: src/cbpm_gpe_cells.sv
// General-purpose event status and enable cells, one per event bit.
// Assumes set pulses and writes come from the same clock as the cells.
module cbpm_gpe_cells #(
    parameter int WIDTH = 16
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    input wire logic clear,
    // Events and writes
    input wire logic [WIDTH-1:0] set_in,
    input wire logic [WIDTH-1:0] w1c_in,
    input wire logic en_we,
    input wire logic [WIDTH-1:0] en_wdata,
    // State
    output logic [WIDTH-1:0] status_r,
    output logic [WIDTH-1:0] enable_r,
    output logic event_out
);
    logic [WIDTH-1:0] status_nxt;
    logic [WIDTH-1:0] enable_nxt;

    if (WIDTH < 1 || WIDTH > 16) begin : g_bad_width
        $error("cbpm_gpe_cells: WIDTH must be 1 to 16");
    end

    // A clear in the same cycle as a set wins, so that event is lost.
    for (genvar i = 0; i < WIDTH; i++) begin : g_cell
        always_comb begin
            if (clear) begin
                status_nxt[i] = 1'b0;
                enable_nxt[i] = 1'b0;
            end else begin
                status_nxt[i] = set_in[i] | (status_r[i] & ~w1c_in[i]);
                enable_nxt[i] = en_we ? en_wdata[i] : enable_r[i];
            end
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            status_r <= '0;
            enable_r <= '0;
        end else begin
            status_r <= status_nxt;
            enable_r <= enable_nxt;
        end
    end

    assign event_out = |(status_r & enable_r);

    set_wins_a: assert property (@(posedge clk) disable iff (rst)
        !clear && set_in[0] |=> status_r[0])
        else $error("event status bit lost its set");
endmodule

// file: src/cbpm_pkg.sv
// Types shared by the bridge power logic.
// Assumes the register header is on the include path.
`include "cbpm_regs.svh"
package cbpm_pkg;
    typedef enum logic [1:0] {
        PWR_D0 = `CBPM_PWR_D0,
        PWR_D1 = `CBPM_PWR_D1,
        PWR_D2 = `CBPM_PWR_D2,
        PWR_D3HOT = `CBPM_PWR_D3HOT
    } cbpm_pwr_t;
    typedef enum logic {DS_UNINIT, DS_ACTIVE} cbpm_phase_t;
endpackage

// file: src/cbpm_power_mgmt.sv
// Power-management logic of a bus-to-card bridge: suspend gating, ring routing,
// power states, capability registers, wake context and event cells.
// Assumes all pins but the clock are asynchronous and config accesses are one-cycle strobes.
`include "cbpm_regs.svh"

// Summary of operation
// - Suspend blocks bus reset and global reset so registers survive.
// - Suspend stops the internal clock unless a granted transaction runs.
// - While suspended all bus outputs are released to high impedance.
// - Status change and ring paths need no clock; serial interrupts restart it.
// - Pins and ring output keep working in suspend unless disabled.
// - Ring output fires on modem ring or card status change wake.
// - Modem ring passes only with its enable and a powered 16-bit card.
// - Card wake uses the status change mask as its enable.
// - Ring goes to shared pin or pin two or four when enabled.
// - Select zero shares the pin; ring beats wake when both enabled.
// - Before initialisation no wake event and no card interrupt are raised; status change interrupts still pass.
// - Both space enables set move the device to active.
// - Bus reset release re-enters uninitialised; global reset forces it at once.
// - The two-bit power field codes only D0, D1, D2 and D3hot.
// - Status capability flag reads one.
// - Capability pointer sits at offset 14h.
// - Capability block starts with ID 01h and a zero next pointer.
// - Header at A0h, control and status with extensions at A4h.
// - With wake enabled bus reset keeps wake context, otherwise clears it.
// - Event status at A8h, enables at AAh; enabled status raises an event.
// - Wake enable is bit 8 of the power control and status register.
module cbpm_power_mgmt import cbpm_pkg::*; #(
    parameter logic [15:0] PM_CAPS = 16'h0002,
    parameter int OE_W = 4,
    parameter int GPE_W = 16
) (
    // Clock and power-on reset
    input wire logic clk,
    input wire logic rst,
    // Power and bus pins
    input wire logic suspend_n,
    input wire logic bus_reset_input_n,
    input wire logic global_reset_input_n,
    input wire logic gnt_n,
    // Configuration access
    input wire logic cfg_wr,
    input wire logic cfg_rd,
    input wire logic [7:0] cfg_addr,
    input wire logic [3:0] cfg_be,
    input wire logic [31:0] cfg_wdata,
    output logic [31:0] cfg_rdata_r,
    // Command and card control bits held elsewhere
    input wire logic cmd_io_en,
    input wire logic cmd_mem_en,
    input wire logic ring_pass_enable,
    input wire logic status_change_mask,
    input wire logic ring_output_enable,
    input wire logic ring_pin_select,
    input wire logic ring_to_pin_four,
    // Card side
    input wire logic card16_powered,
    input wire logic card_ring_indicate_n,
    input wire logic cardbus_wake,
    input wire logic card_csc_in,
    input wire logic csc_serial_mode,
    input wire logic card_irq_in,
    input wire logic [GPE_W-1:0] gpe_set_in,
    // Bus output enables from the bus interface core
    input wire logic [OE_W-1:0] core_oe,
    output logic [OE_W-1:0] pin_oe,
    // Clock control and events
    output logic pclk_run,
    output logic csc_irq_out,
    output logic irq_out,
    output logic gpe_event,
    // Ring and wake pins
    output logic ring_pme_pin,
    output logic multipurpose_pin_two,
    output logic multipurpose_pin_four
);
    localparam int SW = `CBPM_SYNC_W;

    logic [SW-1:0] pins;
    logic [SW-1:0] s1_r, s2_r, s3_r, flt_r, dly_r;
    logic [SW-1:0] s1_nxt, s2_nxt, s3_nxt, flt_nxt, dly_nxt;
    logic suspended, bus_reset_input_eff, global_reset_input_eff, bus_reset_input_q_r, bus_reset_input_q_nxt;
    cbpm_phase_t phase_r, phase_nxt;
    cbpm_pwr_t power_state_field_r, power_state_field_nxt;
    logic wake_event_enable_r, wake_event_enable_nxt;
    logic pme_status_r, pme_status_nxt;
    logic wake_evt, ctx_clear, acc_ok, wr_csr, wr_gpe;
    logic ring_16, ring_cb, ring_active, pme_active;
    logic [31:0] rdata_nxt;
    logic [15:0] pm_csr;
    logic [GPE_W-1:0] gpe_status, gpe_enable, gpe_w1c;
    logic [15:0] lane_mask;
    logic gpe_raw;

    if (OE_W < 1 || GPE_W < 1 || GPE_W > 16) begin : g_bad_param
        $error("cbpm_power_mgmt: OE_W must be at least 1 and GPE_W 1 to 16");
    end

    // Pins cross through three stages; a level counts once stages two and three agree.
    assign pins = {card_ring_indicate_n, cardbus_wake, gnt_n,
                   global_reset_input_n, bus_reset_input_n, suspend_n};
    for (genvar i = 0; i < SW; i++) begin : g_sync
        always_comb begin
            s1_nxt[i] = pins[i];
            s2_nxt[i] = s1_r[i];
            s3_nxt[i] = s2_r[i];
            flt_nxt[i] = (s2_r[i] == s3_r[i]) ? s2_r[i] : flt_r[i];
            dly_nxt[i] = flt_r[i];
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            s1_r <= `CBPM_SYNC_RST;
            s2_r <= `CBPM_SYNC_RST;
            s3_r <= `CBPM_SYNC_RST;
            flt_r <= `CBPM_SYNC_RST;
            dly_r <= `CBPM_SYNC_RST;
        end else begin
            s1_r <= s1_nxt;
            s2_r <= s2_nxt;
            s3_r <= s3_nxt;
            flt_r <= flt_nxt;
            dly_r <= dly_nxt;
        end
    end

    assign suspended = ~flt_r[`CBPM_SI_SUSPEND];
    assign bus_reset_input_eff = ~flt_r[`CBPM_SI_BUS_RST] & ~suspended;
    assign global_reset_input_eff = ~flt_r[`CBPM_SI_GLB_RST] & ~suspended;

    // The bus floats in suspend, so the device cannot be addressed then.
    assign pin_oe = core_oe & {OE_W{~suspended}};
    // A serial interrupt frame needs a running clock to carry a pending status change.
    assign pclk_run = ~suspended | ~flt_r[`CBPM_SI_GNT]
                      | (csc_serial_mode & card_csc_in);
    assign csc_irq_out = card_csc_in;

    // Ring paths are combinational from the pins so they work with the clock stopped.
    assign ring_16 = card16_powered & ring_pass_enable & ~card_ring_indicate_n;
    assign ring_cb = status_change_mask & cardbus_wake;
    assign ring_active = ring_output_enable & (ring_16 | ring_cb);
    assign pme_active = wake_event_enable_r & pme_status_r & (phase_r != DS_UNINIT);
    // With a shared pin the ring function owns it whenever it is enabled.
    assign ring_pme_pin = (!ring_pin_select && ring_output_enable) ? ring_active
                          : pme_active;
    assign multipurpose_pin_two = ring_pin_select & ~ring_to_pin_four & ring_active;
    assign multipurpose_pin_four = ring_pin_select & ring_to_pin_four & ring_active;
    assign irq_out = card_irq_in & (phase_r != DS_UNINIT);

    assign wake_evt = (flt_r[`CBPM_SI_CSTSCHG] & ~dly_r[`CBPM_SI_CSTSCHG])
                      | (~flt_r[`CBPM_SI_RING] & dly_r[`CBPM_SI_RING]);
    assign ctx_clear = global_reset_input_eff | (bus_reset_input_eff & ~wake_event_enable_r);
    assign acc_ok = ~suspended & ~global_reset_input_eff & ~bus_reset_input_eff;
    assign wr_csr = cfg_wr & acc_ok & (cfg_addr == `CBPM_OFF_PM_CSR);
    assign wr_gpe = cfg_wr & acc_ok & (cfg_addr == `CBPM_OFF_GPE_STS);
    assign pm_csr = {pme_status_r, 6'h00, wake_event_enable_r, 6'h00, power_state_field_r};

    always_comb begin
        phase_nxt = phase_r;
        power_state_field_nxt = power_state_field_r;
        wake_event_enable_nxt = wake_event_enable_r;
        pme_status_nxt = pme_status_r;
        bus_reset_input_q_nxt = bus_reset_input_eff;
        if (global_reset_input_eff || bus_reset_input_eff || (bus_reset_input_q_r && !bus_reset_input_eff)) begin
            phase_nxt = DS_UNINIT;
        end else if (phase_r == DS_UNINIT && cmd_io_en && cmd_mem_en) begin
            phase_nxt = DS_ACTIVE;
        end
        if (global_reset_input_eff || bus_reset_input_eff) begin
            power_state_field_nxt = PWR_D0;
        end else if (wr_csr && cfg_be[0]) begin
            power_state_field_nxt = cbpm_pwr_t'(cfg_wdata[1:0]);
        end
        if (ctx_clear) begin
            wake_event_enable_nxt = 1'b0;
            pme_status_nxt = 1'b0;
        end else begin
            if (wr_csr && cfg_be[1]) begin
                wake_event_enable_nxt = cfg_wdata[`CBPM_PME_EN_BIT];
            end
            if (wake_evt) begin
                pme_status_nxt = 1'b1;
            end else if (wr_csr && cfg_be[1] && cfg_wdata[`CBPM_PME_STS_BIT]) begin
                pme_status_nxt = 1'b0;
            end
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            phase_r <= DS_UNINIT;
            power_state_field_r <= PWR_D0;
            wake_event_enable_r <= 1'b0;
            pme_status_r <= 1'b0;
            bus_reset_input_q_r <= 1'b0;
        end else begin
            phase_r <= phase_nxt;
            power_state_field_r <= power_state_field_nxt;
            wake_event_enable_r <= wake_event_enable_nxt;
            pme_status_r <= pme_status_nxt;
            bus_reset_input_q_r <= bus_reset_input_q_nxt;
        end
    end

    // Status bits clear on a written one; enables take the upper half of the doubleword.
    assign lane_mask = {{8{cfg_be[1]}}, {8{cfg_be[0]}}};
    assign gpe_w1c = wr_gpe ? (cfg_wdata[GPE_W-1:0] & lane_mask[GPE_W-1:0]) : '0;

    cbpm_gpe_cells #(.WIDTH(GPE_W)) u_gpe (
        .clk(clk),
        .rst(rst),
        .clear(global_reset_input_eff),
        .set_in(gpe_set_in),
        .w1c_in(gpe_w1c),
        .en_we(wr_gpe && cfg_be[2] && cfg_be[3]),
        .en_wdata(cfg_wdata[16 +: GPE_W]),
        .status_r(gpe_status),
        .enable_r(gpe_enable),
        .event_out(gpe_raw)
    );
    assign gpe_event = gpe_raw & (phase_r != DS_UNINIT);

    always_comb begin
        rdata_nxt = cfg_rdata_r;
        if (cfg_rd && !suspended) begin
            rdata_nxt = 32'h0000_0000;
            case (cfg_addr)
                `CBPM_OFF_CMD_STS: rdata_nxt[`CBPM_CAP_LIST_BIT] = 1'b1;
                `CBPM_OFF_CAP_PTR: rdata_nxt[7:0] = `CBPM_OFF_PM_HDR;
                `CBPM_OFF_PM_HDR: rdata_nxt = {PM_CAPS, `CBPM_CAP_NEXT, `CBPM_CAP_ID};
                `CBPM_OFF_PM_CSR: rdata_nxt = {16'h0000, pm_csr};
                `CBPM_OFF_GPE_STS: begin
                    rdata_nxt[GPE_W-1:0] = gpe_status;
                    rdata_nxt[16 +: GPE_W] = gpe_enable;
                end
                default: rdata_nxt = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cfg_rdata_r <= 32'h0000_0000;
        end else begin
            cfg_rdata_r <= rdata_nxt;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    sequence rd_caps_s;
        cfg_rd && !suspended && cfg_addr == `CBPM_OFF_CMD_STS;
    endsequence
    sequence rd_hdr_s;
        cfg_rd && !suspended && cfg_addr == `CBPM_OFF_PM_HDR;
    endsequence

    bus_float_a: assert property (suspended |-> pin_oe == '0)
        else $error("bus outputs driven during suspend");
    clk_stop_a: assert property (suspended && flt_r[`CBPM_SI_GNT] && !csc_serial_mode
        |-> !pclk_run)
        else $error("clock kept running in idle suspend");
    uninit_quiet_a: assert property (phase_r == DS_UNINIT |-> !ring_pme_pin_pme() )
        else $error("wake or interrupt raised before initialisation");
    active_entry_a: assert property (phase_r == DS_UNINIT && cmd_io_en && cmd_mem_en
        && !global_reset_input_eff && !bus_reset_input_eff && !bus_reset_input_q_r |=> phase_r == DS_ACTIVE)
        else $error("missed move to active state");
    global_reset_input_force_a: assert property (global_reset_input_eff |=> phase_r == DS_UNINIT
        && power_state_field_r == PWR_D0 && !wake_event_enable_r)
        else $error("global reset did not force uninitialised state");
    susp_hold_a: assert property (suspended |=> $stable(power_state_field_r)
        && $stable(wake_event_enable_r))
        else $error("registers changed during suspend");
    ctx_keep_a: assert property (bus_reset_input_eff && !global_reset_input_eff && wake_event_enable_r
        |=> wake_event_enable_r [*2])
        else $error("bus reset lost wake context");
    ctx_drop_a: assert property (bus_reset_input_eff && !wake_event_enable_r
        |=> !pme_status_r && !wake_event_enable_r)
        else $error("bus reset kept context with wake disabled");
    ring_share_a: assert property (!ring_pin_select && ring_output_enable
        |-> ring_pme_pin == ring_active && !multipurpose_pin_two)
        else $error("shared pin not owned by ring function");
    cap_flag_a: assert property (rd_caps_s |=> cfg_rdata_r[`CBPM_CAP_LIST_BIT])
        else $error("capability flag read as zero");
    cap_hdr_a: assert property (rd_hdr_s |=> cfg_rdata_r[15:0] == 16'h0001)
        else $error("capability header wrong");

    function automatic logic ring_pme_pin_pme();
        return pme_active | irq_out | gpe_event;
    endfunction
endmodule

// file: src/cbpm_regs.svh
// Register offsets, field positions, codes and reset values of the bridge power logic.
// Assumes configuration offsets are byte addresses of aligned doublewords.
`ifndef CBPM_REGS_SVH
`define CBPM_REGS_SVH

`define CBPM_OFF_CMD_STS 8'h04
`define CBPM_OFF_CAP_PTR 8'h14
`define CBPM_OFF_PM_HDR 8'hA0
`define CBPM_OFF_PM_CSR 8'hA4
`define CBPM_OFF_GPE_STS 8'hA8
`define CBPM_OFF_GPE_EN 8'hAA

`define CBPM_CAP_LIST_BIT 20
`define CBPM_CAP_ID 8'h01
`define CBPM_CAP_NEXT 8'h00
`define CBPM_PME_EN_BIT 8
`define CBPM_PME_STS_BIT 15

`define CBPM_PWR_D0 2'h0
`define CBPM_PWR_D1 2'h1
`define CBPM_PWR_D2 2'h2
`define CBPM_PWR_D3HOT 2'h3

`define CBPM_SYNC_W 6
`define CBPM_SYNC_RST 6'h2F
`define CBPM_SI_SUSPEND 0
`define CBPM_SI_BUS_RST 1
`define CBPM_SI_GLB_RST 2
`define CBPM_SI_GNT 3
`define CBPM_SI_CSTSCHG 4
`define CBPM_SI_RING 5

`endif

// file: verif/cbpm_host_model.sv
// Host-side model: the power controller driving suspend and both reset pins,
// and the arbiter granting the bus to the bridge.
// Assumes the bench gives its commands just after a rising edge of clk.
module cbpm_host_model (
    // Clock
    input wire logic clk,
    // Commands from the bench
    input wire logic susp_cmd,
    input wire logic bus_reset_input_cmd,
    input wire logic global_reset_input_cmd,
    input wire logic xfer_cmd,
    // Pins toward the bridge
    output logic suspend_n,
    output logic bus_reset_input_n,
    output logic global_reset_input_n,
    output logic gnt_n
);
    timeunit 1ns;
    timeprecision 100ps;
    initial begin
        suspend_n = 1'b1;
        bus_reset_input_n = 1'b1;
        global_reset_input_n = 1'b1;
        gnt_n = 1'b1;
    end
    always @(posedge clk) begin
        suspend_n <= #1 !susp_cmd;
        bus_reset_input_n <= #1 !bus_reset_input_cmd;
        global_reset_input_n <= #1 !global_reset_input_cmd;
        // The grant follows real transfers only, never parked while the bridge floats.
        gnt_n <= #1 !xfer_cmd;
    end
endmodule

// file: verif/testbench.sv
// Self-checking bench for the bridge power logic.
// Assumes the host model drives the power pins and the bench drives all else.
`include "cbpm_regs.svh"
module testbench;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk, rst, susp_cmd, bus_reset_input_cmd, global_reset_input_cmd, xfer_cmd;
    logic suspend_n, bus_reset_input_n, global_reset_input_n, gnt_n;
    logic cfg_wr, cfg_rd, cmd_io_en, cmd_mem_en, ring_pass_enable, status_change_mask;
    logic ring_output_enable, ring_pin_select, ring_to_pin_four, card16_powered;
    logic card_ring_indicate_n, cardbus_wake, card_csc_in, card_irq_in, csc_serial_mode;
    logic pclk_run, csc_irq_out, irq_out, gpe_event;
    logic ring_pme_pin, multipurpose_pin_two, multipurpose_pin_four;
    logic [7:0] cfg_addr;
    logic [3:0] cfg_be, core_oe, pin_oe;
    logic [31:0] cfg_wdata, cfg_rdata_r, rd;
    logic [15:0] gpe_set_in;
    int errors, checks_done;

    cbpm_host_model i_host (.clk, .susp_cmd, .bus_reset_input_cmd, .global_reset_input_cmd, .xfer_cmd,
        .suspend_n, .bus_reset_input_n, .global_reset_input_n, .gnt_n);
    cbpm_power_mgmt i_dut (.clk, .rst, .suspend_n, .bus_reset_input_n,
        .global_reset_input_n, .gnt_n, .cfg_wr, .cfg_rd, .cfg_addr, .cfg_be, .cfg_wdata,
        .cfg_rdata_r, .cmd_io_en, .cmd_mem_en, .ring_pass_enable, .status_change_mask,
        .ring_output_enable, .ring_pin_select, .ring_to_pin_four, .card16_powered,
        .card_ring_indicate_n, .cardbus_wake, .card_csc_in, .csc_serial_mode,
        .card_irq_in, .gpe_set_in, .core_oe, .pin_oe, .pclk_run, .csc_irq_out, .irq_out,
        .gpe_event, .ring_pme_pin, .multipurpose_pin_two, .multipurpose_pin_four);

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            errors++;
            $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
        end
    endtask
    task automatic chk1(input logic got, input logic exp);
        chk32({31'h0, got}, {31'h0, exp});
    endtask
    task automatic cfg_write(input logic [7:0] a, input logic [3:0] be, input logic [31:0] d);
        cfg_addr = a;
        cfg_be = be;
        cfg_wdata = d;
        cfg_wr = 1'b1;
        step(1);
        cfg_wr = 1'b0;
    endtask
    task automatic cfg_read(input logic [7:0] a);
        cfg_addr = a;
        cfg_rd = 1'b1;
        step(1);
        cfg_rd = 1'b0;
        step(1);
        rd = cfg_rdata_r;
    endtask
    // Pins pass a three-stage synchroniser, so each change is given seven cycles.
    task automatic pins(input logic s, input logic p, input logic g);
        susp_cmd = s;
        bus_reset_input_cmd = p;
        global_reset_input_cmd = g;
        step(7);
    endtask
    task automatic ring(input logic [7:0] v, input logic [2:0] exp);
        {card16_powered, card_ring_indicate_n, cardbus_wake, ring_pass_enable} = v[7:4];
        {status_change_mask, ring_output_enable, ring_pin_select, ring_to_pin_four} = v[3:0];
        step(1);
        chk32({29'h0, ring_pme_pin, multipurpose_pin_two, multipurpose_pin_four}, {29'h0, exp});
    endtask

    task automatic t_caps;
        cfg_read(`CBPM_OFF_CMD_STS);
        chk1(rd[20], 1'b1);
        cfg_read(`CBPM_OFF_CAP_PTR);
        chk32({24'h0, rd[7:0]}, 32'h000000A0);
        cfg_read(`CBPM_OFF_PM_HDR);
        chk32(rd, 32'h00020001);
    endtask
    task automatic t_init_gpe;
        cfg_write(`CBPM_OFF_GPE_STS, 4'hC, 32'h00080000);
        gpe_set_in = 16'h0028;
        step(1);
        gpe_set_in = 16'h0000;
        step(1);
        chk1(gpe_event, 1'b0);
        chk1(irq_out, 1'b0);
        cmd_io_en = 1'b1;
        step(3);
        chk1(irq_out, 1'b0);
        cmd_mem_en = 1'b1;
        step(2);
        chk1(irq_out, 1'b1);
        chk1(gpe_event, 1'b1);
        cfg_read(`CBPM_OFF_GPE_STS);
        chk32(rd, 32'h00080028);
        cfg_write(`CBPM_OFF_GPE_STS, 4'h1, 32'h00000008);
        step(1);
        chk1(gpe_event, 1'b0);
    endtask
    task automatic t_power;
        for (int i = 0; i < 4; i++) begin
            cfg_write(`CBPM_OFF_PM_CSR, 4'h1, i);
            cfg_read(`CBPM_OFF_PM_CSR);
            chk32({30'h0, rd[1:0]}, i);
        end
    endtask
    // Wake status is lost on bus reset unless the wake enable keeps it.
    task automatic t_context(input logic en);
        cfg_write(`CBPM_OFF_PM_CSR, 4'h2, {23'h0, en, 8'h00});
        cardbus_wake = 1'b1;
        step(7);
        cardbus_wake = 1'b0;
        cmd_io_en = 1'b0;
        pins(1'b0, 1'b1, 1'b0);
        pins(1'b0, 1'b0, 1'b0);
        chk1(irq_out, 1'b0);
        cfg_read(`CBPM_OFF_PM_CSR);
        chk32({30'h0, rd[15], rd[8]}, {30'h0, en, en});
        cmd_io_en = 1'b1;
    endtask
    task automatic t_suspend;
        chk32({28'h0, pin_oe}, 32'h0000000F);
        xfer_cmd = 1'b1;
        pins(1'b1, 1'b0, 1'b0);
        chk1(pclk_run, 1'b1);
        chk32({28'h0, pin_oe}, 32'h0);
        xfer_cmd = 1'b0;
        step(7);
        chk1(pclk_run, 1'b0);
        card_csc_in = 1'b1;
        ring(8'h95, 3'b100);
        chk1(csc_irq_out, 1'b1);
        chk1(pclk_run, 1'b0);
        csc_serial_mode = 1'b1;
        step(1);
        chk1(pclk_run, 1'b1);
        csc_serial_mode = 1'b0;
        card_csc_in = 1'b0;
        pins(1'b1, 1'b0, 1'b1);
        pins(1'b1, 1'b0, 1'b0);
        pins(1'b0, 1'b0, 1'b0);
        cfg_read(`CBPM_OFF_PM_CSR);
        chk1(rd[8], 1'b1);
        cmd_io_en = 1'b0;
        pins(1'b0, 1'b0, 1'b1);
        pins(1'b0, 1'b0, 1'b0);
        cfg_read(`CBPM_OFF_PM_CSR);
        chk32({30'h0, rd[15], rd[8]}, 32'h0);
    endtask
    task automatic t_ring;
        ring(8'h95, 3'b100);
        ring(8'h85, 3'b000);
        ring(8'h15, 3'b000);
        ring(8'h7D, 3'b100);
        ring(8'h75, 3'b000);
        ring(8'h91, 3'b000);
        ring(8'h96, 3'b010);
        ring(8'h97, 3'b001);
        ring(8'h48, 3'b000);
        step(7);
        cfg_write(`CBPM_OFF_PM_CSR, 4'h2, 32'h00000100);
        // A synchronised card wake sets the wake status that the shared pin shows.
        cardbus_wake = 1'b1;
        step(7);
        cardbus_wake = 1'b0;
        step(1);
        chk1(ring_pme_pin, 1'b0);
        cmd_io_en = 1'b1;
        step(3);
        chk1(irq_out, 1'b1);
        chk1(ring_pme_pin, 1'b1);
        ring(8'h4C, 3'b000);
    endtask

    task automatic tally_and_finish;
        $display("checks %0d, errors %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    initial begin
        #20000;
        errors++;
        tally_and_finish;
    end
    initial begin
        {rst, susp_cmd, bus_reset_input_cmd, global_reset_input_cmd, xfer_cmd, cfg_wr, cfg_rd} = 7'h40;
        {cmd_io_en, cmd_mem_en, status_change_mask, ring_output_enable} = 4'h0;
        {ring_pass_enable, ring_pin_select, ring_to_pin_four, card16_powered} = 4'h0;
        {card_ring_indicate_n, cardbus_wake, card_csc_in, card_irq_in} = 4'h9;
        csc_serial_mode = 1'b0;
        {cfg_addr, cfg_be, cfg_wdata, gpe_set_in, core_oe} = '0;
        core_oe = 4'hF;
        errors = 0;
        checks_done = 0;
        step(10);
        rst = 1'b0;
        step(6);
        t_caps;
        t_init_gpe;
        t_power;
        t_context(1'b0);
        t_context(1'b1);
        t_suspend;
        t_ring;
        tally_and_finish;
    end
endmodule
